// [rtl/uatx_params.svh]
// Register offsets, field positions, reset values and frame bit counts for uatx.
`ifndef UATX_PARAMS_SVH
`define UATX_PARAMS_SVH
`define UATX_AW 3
`define UATX_OFS_TX_STATUS_CONTROL 3'h0
`define UATX_OFS_RX_STATUS_CONTROL 3'h1
`define UATX_OFS_BAUD_LINE_CONTROL 3'h2
`define UATX_OFS_BAUD_DIVIDER_LOW 3'h3
`define UATX_OFS_BAUD_DIVIDER_HIGH 3'h4
`define UATX_OFS_TX_HOLDING_DATA 3'h5
`define UATX_OFS_IRQ_CONTROL 3'h6
`define UATX_TXS_CLK_SRC 7
`define UATX_TXS_NINE 6
`define UATX_TXS_TRANSMIT_ENABLE_BIT 5
`define UATX_TXS_SYNC 4
`define UATX_TXS_BREAK 3
`define UATX_TXS_BAUD_HIGH_SPEED 2
`define UATX_TXS_SHIFT_EMPTY_STATUS 1
`define UATX_TXS_NINTH 0
`define UATX_RXS_SERIAL_PORT_ENABLE 7
`define UATX_BLC_INV 4
`define UATX_BLC_WIDE 3
`define UATX_IRQ_GIE 7
`define UATX_IRQ_PERIPHERAL_IRQ_ENABLE 6
`define UATX_IRQ_TX_IRQ_ENABLE 4
`define UATX_IRQ_FLAG 0
`define UATX_RST_BYTE 8'h00
`define UATX_BITS_EIGHT 4'h8
`define UATX_BITS_NINE 4'h9
`endif

// [rtl/uatx_pkg.sv]
// Types shared by the asynchronous transmitter.
package uatx_pkg;
	typedef enum logic [3:0] {
		UATX_IDLE = 4'b0001,
		UATX_START = 4'b0010,
		UATX_DATA = 4'b0100,
		UATX_STOP = 4'b1000
	} uatx_state_e;
	typedef logic [8:0] uatx_char_t;
endpackage

// [rtl/uatx_transmitter.sv]
// Asynchronous serial transmitter with register port and baud tick input.
// What this block does
// - Transmitter runs only with enable 1, clocked mode 0, port enable 1.
// - Port enable switches the unit on and drives the serial pin.
// - Setting transmit enable sets the buffer-free flag.
// - Holding write when shifter idle moves data to shifter at once.
// - Queued character moves to shifter one cycle after previous stop bit.
// - Start bit reaches the pin one cycle after loading the shifter.
// - Start bit space, data, stop bit mark; line idles at mark.
// - Data bits leave least significant first, one baud period each.
// - Invert bit set inverts whole waveform, idle level included.
// - Inversion applies only in asynchronous mode.
// - Buffer-free flag set when enabled and holding register empty.
// - Buffer-free flag reflects a holding write in the second cycle.
// - Buffer-free flag is read-only; only the enables and holding state drive it.
// - Flag follows holding state regardless of interrupt enable.
// - All three enables and flag set request an interrupt at once.
// - Shift-empty bit read-only, clears on load, sets when shifted out.
// - Shift-empty bit feeds no interrupt source.
// - Nine-bit select sends nine data bits, otherwise eight.
// - Ninth bit from control register copied with low eight together.
//
// Chosen here: the plain strobed port and the register addresses.
`include "uatx_params.svh"
`timescale 1ns/10ps
`default_nettype none
module uatx_transmitter (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Register port.
	input wire logic [`UATX_AW-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Baud generator.
	input wire logic baud_tick,
	output logic [15:0] baud_divisor,
	output logic baud_high_speed,
	output logic baud_wide_counter,
	// Serial line.
	output logic serial_out_pin,
	output logic serial_out_pin_oe,
	// Interrupt request.
	output logic tx_irq_req
);
	logic rst_meta;
	logic rst_n;
	logic nine_bit_select;
	logic transmit_enable_bit;
	logic clocked_mode;
	logic ninth_data_bit;
	logic [1:0] tx_misc;
	logic serial_port_enable;
	logic [3:0] rx_misc;
	logic tx_invert_select;
	logic [1:0] baud_misc;
	logic [7:0] div_low;
	logic [7:0] div_high;
	logic global_irq_enable;
	logic peripheral_irq_enable;
	logic tx_irq_enable;
	logic tx_buffer_free_flag;
	logic hold_full;
	uatx_pkg::uatx_char_t tx_holding_register;
	uatx_pkg::uatx_char_t tx_shift_register;
	uatx_pkg::uatx_state_e state;
	uatx_pkg::uatx_state_e next_state;
	logic [3:0] bit_cnt;
	logic [3:0] frame_bits;
	logic [7:0] next_rdata;
	logic next_pin;

	function automatic logic [3:0] bits_of(input logic nine);
		bits_of = nine ? `UATX_BITS_NINE : `UATX_BITS_EIGHT;
	endfunction

	function automatic logic line_level(input logic raw, input logic inv);
		line_level = raw ^ inv;
	endfunction

	// Reset is released through two flops; assertion stays asynchronous.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	wire sel_txs = reg_addr == `UATX_OFS_TX_STATUS_CONTROL;
	wire sel_rxs = reg_addr == `UATX_OFS_RX_STATUS_CONTROL;
	wire sel_blc = reg_addr == `UATX_OFS_BAUD_LINE_CONTROL;
	wire sel_dlo = reg_addr == `UATX_OFS_BAUD_DIVIDER_LOW;
	wire sel_dhi = reg_addr == `UATX_OFS_BAUD_DIVIDER_HIGH;
	wire sel_hold = reg_addr == `UATX_OFS_TX_HOLDING_DATA;
	wire sel_irq = reg_addr == `UATX_OFS_IRQ_CONTROL;
	wire wr_txs = reg_wr && sel_txs;
	wire wr_rxs = reg_wr && sel_rxs;
	wire wr_blc = reg_wr && sel_blc;
	wire wr_hold = reg_wr && sel_hold;

	wire st_idle = state == uatx_pkg::UATX_IDLE;
	wire st_start = state == uatx_pkg::UATX_START;
	wire st_data = state == uatx_pkg::UATX_DATA;
	wire st_stop = state == uatx_pkg::UATX_STOP;

	wire tx_active = transmit_enable_bit && !clocked_mode &&
		serial_port_enable;
	wire inv_eff = tx_invert_select && !clocked_mode;
	wire shift_empty_status = st_idle;
	wire direct_load = tx_active && wr_hold && st_idle && !hold_full;
	wire queued_load = tx_active && st_idle && hold_full;
	wire load = direct_load || queued_load;
	wire bit_end = baud_tick;
	wire last_bit = bit_cnt == frame_bits - 4'h1;
	wire [8:0] wr_char = {ninth_data_bit, reg_wdata};

	// Control registers.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_misc <= 2'h0;
			nine_bit_select <= 1'b0;
			transmit_enable_bit <= 1'b0;
			clocked_mode <= 1'b0;
			baud_high_speed <= 1'b0;
			ninth_data_bit <= 1'b0;
		end else if (wr_txs) begin
			tx_misc <= {reg_wdata[`UATX_TXS_CLK_SRC],
				reg_wdata[`UATX_TXS_BREAK]};
			nine_bit_select <= reg_wdata[`UATX_TXS_NINE];
			transmit_enable_bit <= reg_wdata[`UATX_TXS_TRANSMIT_ENABLE_BIT];
			clocked_mode <= reg_wdata[`UATX_TXS_SYNC];
			baud_high_speed <= reg_wdata[`UATX_TXS_BAUD_HIGH_SPEED];
			ninth_data_bit <= reg_wdata[`UATX_TXS_NINTH];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_port_enable <= 1'b0;
			rx_misc <= 4'h0;
		end else if (wr_rxs) begin
			serial_port_enable <= reg_wdata[`UATX_RXS_SERIAL_PORT_ENABLE];
			rx_misc <= reg_wdata[6:3];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_invert_select <= 1'b0;
			baud_wide_counter <= 1'b0;
			baud_misc <= 2'h0;
		end else if (wr_blc) begin
			tx_invert_select <= reg_wdata[`UATX_BLC_INV];
			baud_wide_counter <= reg_wdata[`UATX_BLC_WIDE];
			baud_misc <= reg_wdata[1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_low <= `UATX_RST_BYTE;
			div_high <= `UATX_RST_BYTE;
		end else begin
			if (reg_wr && sel_dlo)
				div_low <= reg_wdata;
			if (reg_wr && sel_dhi)
				div_high <= reg_wdata;
		end
	end

	// The flag bit in this register is not writable.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			global_irq_enable <= 1'b0;
			peripheral_irq_enable <= 1'b0;
			tx_irq_enable <= 1'b0;
		end else if (reg_wr && sel_irq) begin
			global_irq_enable <= reg_wdata[`UATX_IRQ_GIE];
			peripheral_irq_enable <= reg_wdata[`UATX_IRQ_PERIPHERAL_IRQ_ENABLE];
			tx_irq_enable <= reg_wdata[`UATX_IRQ_TX_IRQ_ENABLE];
		end
	end

	assign baud_divisor = {div_high, div_low};

	// Holding register: fills when the shifter is busy.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_full <= 1'b0;
			tx_holding_register <= 9'h000;
		end else if (!tx_active) begin
			hold_full <= 1'b0;
		end else if (wr_hold && !direct_load) begin
			hold_full <= 1'b1;
			tx_holding_register <= wr_char;
		end else if (queued_load) begin
			hold_full <= 1'b0;
		end
	end

	// Registered flag gives the one-cycle lag after a holding write.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			tx_buffer_free_flag <= 1'b0;
		else
			tx_buffer_free_flag <= tx_active &&
				!hold_full;
	end

	assign tx_irq_req = tx_buffer_free_flag && tx_irq_enable &&
		peripheral_irq_enable && global_irq_enable;

	always_comb begin
		next_state = state;
		case (state)
			uatx_pkg::UATX_IDLE: begin
				if (load)
					next_state = uatx_pkg::UATX_START;
			end
			uatx_pkg::UATX_START: begin
				if (bit_end)
					next_state = uatx_pkg::UATX_DATA;
			end
			uatx_pkg::UATX_DATA: begin
				if (bit_end && last_bit)
					next_state = uatx_pkg::UATX_STOP;
			end
			uatx_pkg::UATX_STOP: begin
				if (bit_end)
					next_state = uatx_pkg::UATX_IDLE;
			end
			default: next_state = uatx_pkg::UATX_IDLE;
		endcase
		if (!tx_active)
			next_state = uatx_pkg::UATX_IDLE;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			state <= uatx_pkg::UATX_IDLE;
		else
			state <= next_state;
	end

	// Shifter and bit counter.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_shift_register <= 9'h000;
			bit_cnt <= 4'h0;
			frame_bits <= `UATX_BITS_EIGHT;
		end else if (!tx_active) begin
			tx_shift_register <= 9'h000;
			bit_cnt <= 4'h0;
		end else if (load) begin
			tx_shift_register <= direct_load ? wr_char :
				tx_holding_register;
			bit_cnt <= 4'h0;
			frame_bits <= bits_of(nine_bit_select);
		end else if (st_data && bit_end) begin
			tx_shift_register <= {1'b0, tx_shift_register[8:1]};
			bit_cnt <= bit_cnt + 4'h1;
		end
	end

	always_comb begin
		next_pin = line_level(1'b1, inv_eff);
		if (st_start)
			next_pin = line_level(1'b0, inv_eff);
		else if (st_data)
			next_pin = line_level(tx_shift_register[0], inv_eff);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_out_pin <= 1'b1;
			serial_out_pin_oe <= 1'b0;
		end else begin
			serial_out_pin <= next_pin;
			serial_out_pin_oe <= serial_port_enable;
		end
	end

	// Read mux; write-only and unmapped offsets read zero.
	always_comb begin
		next_rdata = 8'h00;
		if (sel_txs)
			next_rdata = {tx_misc[1], nine_bit_select, transmit_enable_bit,
				clocked_mode, tx_misc[0], baud_high_speed,
				shift_empty_status, ninth_data_bit};
		else if (sel_rxs)
			next_rdata = {serial_port_enable, rx_misc, 3'h0};
		else if (sel_blc)
			next_rdata = {3'h0, tx_invert_select, baud_wide_counter,
				1'b0, baud_misc};
		else if (sel_dlo)
			next_rdata = div_low;
		else if (sel_dhi)
			next_rdata = div_high;
		else if (sel_irq)
			next_rdata = {global_irq_enable, peripheral_irq_enable, 1'b0,
				tx_irq_enable, 3'h0, tx_buffer_free_flag};
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= reg_rd ? next_rdata : 8'h00;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	property p_off_idle;
		!tx_active |=> st_idle && !hold_full;
	endproperty
	a_off_idle: assert property (p_off_idle)
		else $error("disabled transmitter not idle");

	property p_oe;
		$rose(serial_port_enable) |=> serial_out_pin_oe;
	endproperty
	a_oe: assert property (p_oe)
		else $error("pin not driven after port enable");

	property p_flag_on;
		$rose(tx_active) |=> tx_buffer_free_flag;
	endproperty
	a_flag_on: assert property (p_flag_on)
		else $error("flag not set on enable");

	property p_direct;
		direct_load |=> st_start ##1 serial_out_pin == $past(inv_eff);
	endproperty
	a_direct: assert property (p_direct)
		else $error("idle write did not start frame");

	property p_queued;
		st_stop && bit_end && hold_full && tx_active ##1 tx_active
			|-> st_idle ##1 st_start;
	endproperty
	a_queued: assert property (p_queued)
		else $error("queued char not loaded after stop");

	property p_flag_lag;
		wr_hold && tx_active && !st_idle && !hold_full && !bit_end
			##1 tx_active |-> tx_buffer_free_flag ##1 !tx_buffer_free_flag;
	endproperty
	a_flag_lag: assert property (p_flag_lag)
		else $error("flag timing after holding write");

	property p_irq;
		tx_irq_req |-> tx_buffer_free_flag && tx_irq_enable &&
			global_irq_enable && peripheral_irq_enable;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt without flag and enables");

	property p_empty;
		load |=> !shift_empty_status;
	endproperty
	a_empty: assert property (p_empty)
		else $error("shift empty not cleared on load");

	property p_idle_level;
		st_idle |=> serial_out_pin == !$past(inv_eff);
	endproperty
	a_idle_level: assert property (p_idle_level)
		else $error("idle level wrong");

	property p_bits;
		st_data && bit_end && last_bit && tx_active |=> st_stop;
	endproperty
	a_bits: assert property (p_bits)
		else $error("data bit count wrong");

	c_frame: cover property (st_stop && bit_end);
	c_back: cover property (queued_load);
	c_nine: cover property (st_stop && frame_bits == `UATX_BITS_NINE);
	c_irq: cover property (tx_irq_req);
endmodule
`default_nettype wire

// [verification/uatx_rx_model.sv]
// Behavioural serial receiver that decodes frames from the line.
`timescale 1ns/10ps
`default_nettype none
module uatx_rx_model (
	// Clock and baud timing.
	input wire logic clk,
	input wire logic baud_tick,
	// Line and decode setup.
	input wire logic line,
	input wire logic inv,
	input wire logic arm,
	input wire logic [3:0] nbits,
	// Decoded result.
	output logic [8:0] rx_data,
	output var int rx_frames,
	output logic rx_bad
);
	logic [8:0] shf;
	logic lvl;
	logic tick_seen = 1'b0;
	assign lvl = line ^ inv;
	always @(posedge clk) tick_seen <= baud_tick;
	// The pin lags the state by one flop, so each bit is sampled one edge
	// after the tick that closes it; a short first start bit is allowed.
	initial begin
		rx_data = 9'h000;
		rx_frames = 0;
		rx_bad = 1'b0;
		forever begin
			@(posedge clk);
			if (arm && lvl == 1'b0) begin
				shf = 9'h000;
				if (!tick_seen) @(posedge clk iff tick_seen);
				if (lvl !== 1'b0) rx_bad = 1'b1;
				for (int i = 0; i < nbits; i++) begin
					@(posedge clk iff tick_seen);
					shf[i] = lvl;
				end
				@(posedge clk iff tick_seen);
				if (lvl !== 1'b1) rx_bad = 1'b1;
				rx_data = shf;
				rx_frames++;
			end
		end
	end
endmodule
`default_nettype wire

// [verification/tb_uatx_transmitter.sv]
// Self-checking bench for the asynchronous transmitter.
`timescale 1ns/10ps
`default_nettype none
module tb_uatx_transmitter;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic baud_tick = 1'b0;
	logic [2:0] tcnt = 3'h0;
	logic [15:0] baud_divisor;
	logic baud_high_speed;
	logic baud_wide_counter;
	logic serial_out_pin;
	logic serial_out_pin_oe;
	logic tx_irq_req;
	logic inv = 1'b0;
	logic arm = 1'b0;
	logic [3:0] nbits = 4'h8;
	logic [8:0] rx_data;
	int rx_frames;
	logic rx_bad;
	int err_total = 0;
	int cmp_count = 0;
	always #20 clk = ~clk;
	// One tick every eight clocks keeps a frame under a hundred cycles.
	always @(posedge clk) begin
		tcnt <= tcnt + 3'h1;
		baud_tick <= (tcnt == 3'h7);
	end
	uatx_transmitter dut (
		.clk(clk),
		.rst_b(rst_b),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.baud_tick(baud_tick),
		.baud_divisor(baud_divisor),
		.baud_high_speed(baud_high_speed),
		.baud_wide_counter(baud_wide_counter),
		.serial_out_pin(serial_out_pin),
		.serial_out_pin_oe(serial_out_pin_oe),
		.tx_irq_req(tx_irq_req)
	);
	uatx_rx_model rxm (
		.clk(clk),
		.baud_tick(baud_tick),
		.line(serial_out_pin),
		.inv(inv),
		.arm(arm),
		.nbits(nbits),
		.rx_data(rx_data),
		.rx_frames(rx_frames),
		.rx_bad(rx_bad)
	);
	task automatic wrap_up();
		if (err_total == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(reg_rdata, e);
	endtask
	task automatic settle();
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic rx(input logic [8:0] e);
		int n;
		n = rx_frames;
		for (int i = 0; i < 400 && rx_frames == n; i++) @(posedge clk);
		chk(16'(rx_frames - n), 16'h0001);
		chk(rx_data, e);
		chk(rx_bad, 1'b0);
	endtask
	task automatic t_reset();
		for (int a = 0; a < 8; a++) rdchk(3'(a), a == 0 ? 8'h02 : 8'h00);
		chk(serial_out_pin_oe, 1'b0);
		chk(serial_out_pin, 1'b1);
	endtask
	task automatic t_baud();
		wr(3'h3, 8'h34);
		wr(3'h4, 8'h12);
		wr(3'h0, 8'h04);
		wr(3'h2, 8'h08);
		settle();
		chk(baud_divisor, 16'h1234);
		chk(baud_high_speed, 1'b1);
		chk(baud_wide_counter, 1'b1);
		wr(3'h2, 8'h00);
	endtask
	task automatic t_enable();
		wr(3'h1, 8'h80);
		settle();
		chk(serial_out_pin_oe, 1'b1);
		wr(3'h0, 8'h20);
		rdchk(3'h6, 8'h01);
		wr(3'h6, 8'h00);
		rdchk(3'h6, 8'h01);
		wr(3'h6, 8'hd0);
		@(negedge clk);
		chk(tx_irq_req, 1'b1);
		wr(3'h6, 8'h50);
		@(negedge clk);
		chk(tx_irq_req, 1'b0);
		rdchk(3'h6, 8'h51);
	endtask
	task automatic t_frame();
		arm <= 1'b1;
		wr(3'h5, 8'ha5);
		@(posedge clk);
		@(negedge clk);
		chk(serial_out_pin, 1'b0);
		rdchk(3'h0, 8'h20);
		rx(9'h0a5);
		repeat (12) @(posedge clk);
		rdchk(3'h0, 8'h22);
	endtask
	task automatic t_b2b();
		wr(3'h6, 8'hd0);
		wr(3'h5, 8'h3c);
		wr(3'h5, 8'hc3);
		settle();
		chk(tx_irq_req, 1'b0);
		rdchk(3'h6, 8'hd0);
		rx(9'h03c);
		rx(9'h0c3);
		chk(tx_irq_req, 1'b1);
		wr(3'h6, 8'h00);
		repeat (12) @(posedge clk);
	endtask
	task automatic t_nine();
		nbits <= 4'h9;
		wr(3'h0, 8'h61);
		wr(3'h5, 8'h0f);
		rx(9'h10f);
		wr(3'h0, 8'h60);
		wr(3'h5, 8'hf0);
		rx(9'h0f0);
		repeat (12) @(posedge clk);
		nbits <= 4'h8;
		wr(3'h0, 8'h20);
	endtask
	task automatic t_inv();
		arm <= 1'b0;
		wr(3'h2, 8'h10);
		settle();
		chk(serial_out_pin, 1'b0);
		inv <= 1'b1;
		arm <= 1'b1;
		wr(3'h5, 8'h81);
		rx(9'h081);
		repeat (12) @(posedge clk);
		arm <= 1'b0;
		wr(3'h0, 8'h30);
		settle();
		chk(serial_out_pin, 1'b1);
		wr(3'h0, 8'h20);
		wr(3'h2, 8'h00);
		settle();
		inv <= 1'b0;
	endtask
	task automatic t_abort();
		int lows;
		lows = 0;
		wr(3'h5, 8'h00);
		repeat (20) @(posedge clk);
		wr(3'h0, 8'h00);
		settle();
		chk(serial_out_pin, 1'b1);
		rdchk(3'h0, 8'h02);
		rdchk(3'h6, 8'h00);
		wr(3'h5, 8'h55);
		repeat (100) begin
			@(negedge clk);
			if (serial_out_pin !== 1'b1) lows++;
		end
		chk(16'(lows), 16'h0000);
		wr(3'h1, 8'h00);
		settle();
		chk(serial_out_pin_oe, 1'b0);
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_baud();
		t_enable();
		t_frame();
		t_b2b();
		t_nine();
		t_inv();
		t_abort();
		wrap_up();
	end
	initial begin
		#2000000;
		err_total++;
		wrap_up();
	end
endmodule
`default_nettype wire
